// *** rtl/iss_pkg.sv ***
// shared constants for the interrupt and statistics unit
package iss_pkg;

  // ----------------------------------------------------------------
  // cause register layout
  // ----------------------------------------------------------------
  localparam int ISS_CAUSE_W = 16;
  localparam int ISS_NUM_IND = 10;
  localparam int ISS_B_SUMMARY = 0;
  localparam int ISS_B_HOST_FAULT = 1;
  localparam int ISS_B_SEND_DONE = 2;
  localparam int ISS_B_ARRIVAL_DONE = 3;
  localparam int ISS_B_NEAR_FULL = 4;
  localparam int ISS_B_EARLY = 5;
  localparam int ISS_B_SW_REQ = 6;
  localparam int ISS_B_LINK = 7;
  localparam int ISS_B_SEND_XFER = 8;
  localparam int ISS_B_ARRIVAL_XFER = 9;
  localparam int ISS_B_CTRL_FRAME = 10;
  localparam logic [15:0] ISS_CAUSE_RST = 16'h0000;
  localparam logic [15:0] ISS_MASK_RST = 16'h0000;
  // bits cleared by writing a one
  localparam logic [15:0] ISS_W1C_BITS = 16'h07E1;
  // bits that exist in the mask register
  localparam logic [15:0] ISS_IND_BITS = 16'h07FE;

  // ----------------------------------------------------------------
  // statistics counters
  // ----------------------------------------------------------------
  localparam int ISS_NUM_CTR = 16;
  localparam int ISS_SEL_W = 4;
  localparam int ISS_AMT_W = 16;
  localparam int ISS_DATA_W = 32;
  localparam int ISS_FRAME_CTR_W = 16;
  localparam int ISS_BYTE_CTR_W = 32;
  localparam logic [4:0] ISS_COLL_ONE = 5'h01;
  localparam logic [4:0] ISS_COLL_MANY_MIN = 5'h02;
  localparam logic [4:0] ISS_COLL_MANY_MAX = 5'h0F;
  localparam logic [15:0] ISS_AMT_ONE = 16'h0001;
  localparam int ISS_C_TX_FRAMES = 0;
  localparam int ISS_C_TX_BCAST = 1;
  localparam int ISS_C_TX_MCAST = 2;
  localparam int ISS_C_TX_BYTES = 3;
  localparam int ISS_C_DEFERRED = 4;
  localparam int ISS_C_LONG_DEFER = 5;
  localparam int ISS_C_ONE_COLL = 6;
  localparam int ISS_C_MANY_COLL = 7;
  localparam int ISS_C_LATE_HIT = 8;
  localparam int ISS_C_COLL_ABORT = 9;
  localparam int ISS_C_CARRIER_DROP = 10;
  localparam int ISS_C_RX_FRAMES = 11;
  localparam int ISS_C_RX_BCAST = 12;
  localparam int ISS_C_RX_MCAST = 13;
  localparam int ISS_C_RX_BYTES = 14;
  localparam int ISS_C_OVERRUN_DROP = 15;

  function automatic int iss_ctr_width(input int idx);
    if (idx == ISS_C_TX_BYTES || idx == ISS_C_RX_BYTES) begin
      return ISS_BYTE_CTR_W;
    end
    return ISS_FRAME_CTR_W;
  endfunction : iss_ctr_width

endpackage : iss_pkg

// *** rtl/iss_stat_ctr.sv ***
// one statistics counter: clear on read, add on write, near-full flag
`timescale 1ns/100ps
module iss_stat_ctr
  import iss_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inc_en,
  input wire logic [ISS_AMT_W-1:0] inc_amt,
  input wire logic rd,
  input wire logic wr,
  input wire logic [ISS_DATA_W-1:0] wr_data,
  output logic [ISS_DATA_W-1:0] value,
  output logic near
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic near_flag;
  logic next_near_flag;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  always_comb begin
    logic [W-1:0] base;
    logic [W-1:0] add_inc;
    logic [W-1:0] add_wr;
    base = rd ? '0 : count;
    add_inc = inc_en ? W'(inc_amt) : '0;
    add_wr = wr ? wr_data[W-1:0] : '0;
    next_count = base + add_inc + add_wr;
    // an increment in the read cycle survives, so no event is lost
    next_near_flag = (near_flag & ~rd) | (next_count[W-1] & next_count[W-2]);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= '0;
      near_flag <= 1'b0;
    end else begin
      count <= next_count;
      near_flag <= next_near_flag;
    end
  end

  assign value = ISS_DATA_W'(count);
  assign near = near_flag;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_read_clears;
    @(posedge core_clk) disable iff (!rst_n)
      (rd && !inc_en && !wr) |=> (count == '0);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("read did not clear counter");

  property p_write_adds;
    @(posedge core_clk) disable iff (!rst_n)
      (wr && !rd && !inc_en) |=> (count == W'($past(count) + $past(wr_data[W-1:0])));
  endproperty
  a_write_adds: assert property (p_write_adds)
    else $error("write did not add to counter");

  property p_near_sets;
    @(posedge core_clk) disable iff (!rst_n)
      (count[W-1] && count[W-2]) |-> near_flag;
  endproperty
  a_near_sets: assert property (p_near_sets)
    else $error("near-full not raised at 75 percent");

endmodule : iss_stat_ctr

// *** rtl/iss_stat_events.sv ***
// decode of transmit and receive frame outcomes into counter increments
`timescale 1ns/100ps
module iss_stat_events
  import iss_pkg::*;
(
  input wire logic counting_on_bit,
  input wire logic tx_frame_end,
  input wire logic tx_ok,
  input wire logic tx_bcast,
  input wire logic tx_mcast,
  input wire logic tx_deferred,
  input wire logic tx_long_defer,
  input wire logic [4:0] tx_coll_cnt,
  input wire logic tx_carrier_lost,
  input wire logic tx_coll_abort,
  input wire logic tx_late_hit,
  input wire logic rx_frame_end,
  input wire logic rx_ok,
  input wire logic rx_bcast,
  input wire logic rx_mcast,
  input wire logic rx_overrun_drop,
  output logic [ISS_NUM_CTR-1:0] inc_en
);

  logic [ISS_NUM_CTR-1:0] raw;
  logic tx_good;
  logic rx_good;

  always_comb begin
    // carrier loss does not spoil a good frame here
    tx_good = tx_frame_end & tx_ok;
    rx_good = rx_frame_end & rx_ok;
    raw = '0;
    raw[ISS_C_TX_FRAMES] = tx_good;
    raw[ISS_C_TX_BCAST] = tx_good & tx_bcast;
    raw[ISS_C_TX_MCAST] = tx_good & tx_mcast;
    raw[ISS_C_TX_BYTES] = tx_good;
    raw[ISS_C_DEFERRED] = tx_frame_end & tx_deferred;
    raw[ISS_C_LONG_DEFER] = tx_frame_end & tx_long_defer;
    raw[ISS_C_ONE_COLL] = tx_good & (tx_coll_cnt == ISS_COLL_ONE);
    raw[ISS_C_MANY_COLL] = tx_good & (tx_coll_cnt >= ISS_COLL_MANY_MIN)
                           & (tx_coll_cnt <= ISS_COLL_MANY_MAX);
    raw[ISS_C_LATE_HIT] = tx_late_hit;
    raw[ISS_C_COLL_ABORT] = tx_frame_end & tx_coll_abort;
    raw[ISS_C_CARRIER_DROP] = tx_good & tx_carrier_lost;
    raw[ISS_C_RX_FRAMES] = rx_good;
    raw[ISS_C_RX_BCAST] = rx_good & rx_bcast;
    raw[ISS_C_RX_MCAST] = rx_good & rx_mcast;
    raw[ISS_C_RX_BYTES] = rx_good;
    raw[ISS_C_OVERRUN_DROP] = rx_frame_end & rx_overrun_drop;
    inc_en = counting_on_bit ? raw : '0;
  end

endmodule : iss_stat_events

// *** rtl/iss_intr_stats.sv ***
// interrupt cause, mask and statistics counters of the fast ethernet mac
//
// Operation
// - ten indications, each gated by its mask bit
// - bit zero flags any asserted interrupt
// - bit zero clears only by writing one
// - host fault stays until resets issued
// - send done clears on send result write
// - arrival done cleared by hardware itself
// - six indications clear by writing one
// - sixteen statistics counters of differing widths
// - counters count only while counting enabled
// - counter read returns value then clears it
// - reads allowed while counting stays enabled
// - counter write adds value to contents
// - near-full at 75 percent, cleared by read
// - good sent frames, bcast, mcast, octets counted
// - count deferred and excessively deferred frames
// - one and two-to-fifteen collision frames counted
// - every late collision counted
// - count frames aborted by excess collisions
// - count good frames that lost carrier
// - good arrived frames, bcast, mcast, octets counted
// - count frames dropped by queue overrun
// - early arrival cleared when arrival done sets
`timescale 1ns/100ps
module iss_intr_stats
  import iss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic host_fault_evt,
  input wire logic host_fault_reset,
  input wire logic send_done_evt,
  input wire logic send_result_wr,
  input wire logic arrival_pending,
  input wire logic early_arrival_evt,
  input wire logic software_request_evt,
  input wire logic link_change_evt,
  input wire logic send_transfer_done_evt,
  input wire logic arrival_transfer_done_evt,
  input wire logic control_frame_seen_evt,
  input wire logic cause_wr,
  input wire logic [ISS_CAUSE_W-1:0] cause_wr_data,
  input wire logic mask_wr,
  input wire logic [ISS_CAUSE_W-1:0] mask_wr_data,
  output logic [ISS_CAUSE_W-1:0] interrupt_cause_reg,
  output logic [ISS_CAUSE_W-1:0] interrupt_mask_reg,
  output logic host_intr_n,
  input wire logic counting_on_bit,
  input wire logic stat_rd,
  input wire logic stat_wr,
  input wire logic [ISS_SEL_W-1:0] stat_sel,
  input wire logic [ISS_DATA_W-1:0] stat_wr_data,
  output logic [ISS_DATA_W-1:0] stat_rd_data,
  input wire logic tx_frame_end,
  input wire logic tx_ok,
  input wire logic tx_bcast,
  input wire logic tx_mcast,
  input wire logic [ISS_AMT_W-1:0] tx_bytes,
  input wire logic tx_deferred,
  input wire logic tx_long_defer,
  input wire logic [4:0] tx_coll_cnt,
  input wire logic tx_carrier_lost,
  input wire logic tx_coll_abort,
  input wire logic tx_late_hit,
  input wire logic rx_frame_end,
  input wire logic rx_ok,
  input wire logic rx_bcast,
  input wire logic rx_mcast,
  input wire logic [ISS_AMT_W-1:0] rx_bytes,
  input wire logic rx_overrun_drop
);

  logic [ISS_CAUSE_W-1:0] cause;
  logic [ISS_CAUSE_W-1:0] next_cause;
  logic [ISS_CAUSE_W-1:0] mask;
  logic [ISS_CAUSE_W-1:0] next_mask;
  logic intr_n;
  logic next_intr_n;
  logic [ISS_DATA_W-1:0] rd_data;
  logic [ISS_DATA_W-1:0] next_rd_data;
  logic [ISS_CAUSE_W-1:0] w1c;
  logic masked_any;
  logic arrival_rise;
  logic [ISS_NUM_CTR-1:0] inc_en;
  logic [ISS_NUM_CTR-1:0] ctr_near;
  logic [ISS_DATA_W-1:0] ctr_val [ISS_NUM_CTR];

  // ----------------------------------------------------------------
  // cause and mask
  // ----------------------------------------------------------------
  always_comb begin
    w1c = cause_wr ? (cause_wr_data & ISS_W1C_BITS) : '0;
    masked_any = |(cause & mask & ISS_IND_BITS);
    arrival_rise = arrival_pending & ~cause[ISS_B_ARRIVAL_DONE];
    next_cause = cause & ~w1c;
    // set beats clear on every flag below except the early flag
    next_cause[ISS_B_SUMMARY] = masked_any
      | (cause[ISS_B_SUMMARY] & ~w1c[ISS_B_SUMMARY]);
    // a cause write never touches the fault flag
    next_cause[ISS_B_HOST_FAULT] = host_fault_evt
      | (cause[ISS_B_HOST_FAULT] & ~host_fault_reset);
    next_cause[ISS_B_SEND_DONE] = send_done_evt
      | (cause[ISS_B_SEND_DONE] & ~send_result_wr);
    // tracks the receive side's pending level, no host action
    next_cause[ISS_B_ARRIVAL_DONE] = arrival_pending;
    next_cause[ISS_B_NEAR_FULL] = |ctr_near;
    // here the automatic clear wins over a new early event
    next_cause[ISS_B_EARLY] = (early_arrival_evt | next_cause[ISS_B_EARLY])
      & ~arrival_rise;
    next_cause[ISS_B_SW_REQ] = next_cause[ISS_B_SW_REQ] | software_request_evt;
    next_cause[ISS_B_LINK] = next_cause[ISS_B_LINK] | link_change_evt;
    next_cause[ISS_B_SEND_XFER] = next_cause[ISS_B_SEND_XFER] | send_transfer_done_evt;
    next_cause[ISS_B_ARRIVAL_XFER] = next_cause[ISS_B_ARRIVAL_XFER]
      | arrival_transfer_done_evt;
    next_cause[ISS_B_CTRL_FRAME] = next_cause[ISS_B_CTRL_FRAME] | control_frame_seen_evt;
    next_cause = next_cause & (ISS_IND_BITS | ISS_CAUSE_W'(1));
    next_mask = mask_wr ? (mask_wr_data & ISS_IND_BITS) : mask;
    next_intr_n = ~masked_any;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cause <= ISS_CAUSE_RST;
      mask <= ISS_MASK_RST;
      intr_n <= 1'b1;
    end else begin
      cause <= next_cause;
      mask <= next_mask;
      intr_n <= next_intr_n;
    end
  end

  assign interrupt_cause_reg = cause;
  assign interrupt_mask_reg = mask;
  assign host_intr_n = intr_n;

  // ----------------------------------------------------------------
  // statistics
  // ----------------------------------------------------------------
  iss_stat_events u_events (
    .counting_on_bit(counting_on_bit),
    .tx_frame_end(tx_frame_end),
    .tx_ok(tx_ok),
    .tx_bcast(tx_bcast),
    .tx_mcast(tx_mcast),
    .tx_deferred(tx_deferred),
    .tx_long_defer(tx_long_defer),
    .tx_coll_cnt(tx_coll_cnt),
    .tx_carrier_lost(tx_carrier_lost),
    .tx_coll_abort(tx_coll_abort),
    .tx_late_hit(tx_late_hit),
    .rx_frame_end(rx_frame_end),
    .rx_ok(rx_ok),
    .rx_bcast(rx_bcast),
    .rx_mcast(rx_mcast),
    .rx_overrun_drop(rx_overrun_drop),
    .inc_en(inc_en)
  );

  for (genvar g = 0; g < ISS_NUM_CTR; g++) begin : g_ctr
    logic [ISS_AMT_W-1:0] amt;
    assign amt = (g == ISS_C_TX_BYTES) ? tx_bytes :
                 (g == ISS_C_RX_BYTES) ? rx_bytes : ISS_AMT_ONE;
    // read and write apply while counting runs, no need to stop it
    iss_stat_ctr #(.W(iss_ctr_width(g))) u_ctr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .inc_en(inc_en[g]),
      .inc_amt(amt),
      .rd(stat_rd && (stat_sel == ISS_SEL_W'(g))),
      .wr(stat_wr && (stat_sel == ISS_SEL_W'(g))),
      .wr_data(stat_wr_data),
      .value(ctr_val[g]),
      .near(ctr_near[g])
    );
  end

  always_comb begin
    // value before the clear is what the host sees
    next_rd_data = stat_rd ? ctr_val[stat_sel] : rd_data;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  assign stat_rd_data = rd_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_masked_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      ((cause & mask & ISS_IND_BITS) == '0) |=> intr_n;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt from masked bit");

  property p_intr_asserts;
    @(posedge core_clk) disable iff (!rst_n)
      ((cause & mask & ISS_IND_BITS) != '0) |=> !intr_n;
  endproperty
  a_intr_asserts: assert property (p_intr_asserts)
    else $error("interrupt line not asserted");

  property p_summary_set;
    @(posedge core_clk) disable iff (!rst_n)
      !intr_n |-> cause[ISS_B_SUMMARY];
  endproperty
  a_summary_set: assert property (p_summary_set)
    else $error("summary clear while asserting");

  property p_summary_clear;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(cause[ISS_B_SUMMARY]) |-> ($past(cause_wr) && $past(cause_wr_data[ISS_B_SUMMARY]));
  endproperty
  a_summary_clear: assert property (p_summary_clear)
    else $error("summary cleared without write");

  property p_fault_holds;
    @(posedge core_clk) disable iff (!rst_n)
      (cause[ISS_B_HOST_FAULT] && !host_fault_reset) |=> cause[ISS_B_HOST_FAULT];
  endproperty
  a_fault_holds: assert property (p_fault_holds)
    else $error("host fault dropped early");

  property p_send_ack;
    @(posedge core_clk) disable iff (!rst_n)
      (send_result_wr && !send_done_evt) |=> !cause[ISS_B_SEND_DONE];
  endproperty
  a_send_ack: assert property (p_send_ack)
    else $error("send done not cleared");

  property p_early_excl;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(cause[ISS_B_ARRIVAL_DONE]) |-> !cause[ISS_B_EARLY];
  endproperty
  a_early_excl: assert property (p_early_excl)
    else $error("early and arrival done together");

  property p_w1c_link;
    @(posedge core_clk) disable iff (!rst_n)
      (cause_wr && cause_wr_data[ISS_B_LINK] && !link_change_evt) |=> !cause[ISS_B_LINK];
  endproperty
  a_w1c_link: assert property (p_w1c_link)
    else $error("link flag not cleared by write");

  property p_count_gate;
    @(posedge core_clk) disable iff (!rst_n)
      !counting_on_bit |-> (inc_en == '0);
  endproperty
  a_count_gate: assert property (p_count_gate)
    else $error("counting while disabled");

  property p_read_value;
    @(posedge core_clk) disable iff (!rst_n)
      stat_rd |=> (rd_data == $past(ctr_val[stat_sel]));
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("read returned wrong value");

  property p_arr_copy;
    @(posedge core_clk) disable iff (!rst_n)
      arrival_pending |=> cause[ISS_B_ARRIVAL_DONE];
  endproperty
  a_arr_copy: assert property (p_arr_copy)
    else $error("arrival flag missed");

  property p_near_cause;
    @(posedge core_clk) disable iff (!rst_n)
      (|ctr_near) |=> cause[ISS_B_NEAR_FULL];
  endproperty
  a_near_cause: assert property (p_near_cause)
    else $error("near-full flag missed");

  property p_send_set;
    @(posedge core_clk) disable iff (!rst_n)
      send_done_evt |=> cause[ISS_B_SEND_DONE];
  endproperty
  a_send_set: assert property (p_send_set)
    else $error("send done flag missed");

  property p_summary_on;
    @(posedge core_clk) disable iff (!rst_n)
      ((cause & mask & ISS_IND_BITS) != '0) |=> cause[ISS_B_SUMMARY];
  endproperty
  a_summary_on: assert property (p_summary_on)
    else $error("summary flag missed");

  property p_fault_set;
    @(posedge core_clk) disable iff (!rst_n)
      host_fault_evt |=> cause[ISS_B_HOST_FAULT];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("host fault flag missed");

endmodule : iss_intr_stats

// *** tb/iss_host_model.sv ***
// host driver model: mask and cause writes, acknowledges, counter accesses
`timescale 1ns/100ps
module iss_host_model
  import iss_pkg::*;
(
  input wire logic core_clk,
  input wire logic [ISS_DATA_W-1:0] stat_rd_data,
  output logic cause_wr,
  output logic [ISS_CAUSE_W-1:0] cause_wr_data,
  output logic mask_wr,
  output logic [ISS_CAUSE_W-1:0] mask_wr_data,
  output logic send_result_wr,
  output logic host_fault_reset,
  output logic stat_rd,
  output logic stat_wr,
  output logic [ISS_SEL_W-1:0] stat_sel,
  output logic [ISS_DATA_W-1:0] stat_wr_data
);
  initial begin
    {cause_wr, mask_wr, send_result_wr, host_fault_reset, stat_rd, stat_wr} = '0;
    {cause_wr_data, mask_wr_data, stat_sel, stat_wr_data} = '0;
  end

  // ----------------------------------------------------------------
  // accesses: one rising edge each, released lines show flipped data
  // ----------------------------------------------------------------
  task automatic write_cause(input logic [ISS_CAUSE_W-1:0] dat);
    @(negedge core_clk);
    cause_wr = 1'b1;
    cause_wr_data = dat;
    @(negedge core_clk);
    cause_wr = 1'b0;
    cause_wr_data = ~dat;
  endtask : write_cause

  // interrupt service always ends by writing one to the summary
  task automatic ack_summary();
    write_cause(16'h0001);
  endtask : ack_summary

  task automatic set_mask(input logic [ISS_CAUSE_W-1:0] dat);
    @(negedge core_clk);
    mask_wr = 1'b1;
    mask_wr_data = dat;
    @(negedge core_clk);
    mask_wr = 1'b0;
    mask_wr_data = ~dat;
  endtask : set_mask

  task automatic ack_send();
    @(negedge core_clk);
    send_result_wr = 1'b1;
    @(negedge core_clk);
    send_result_wr = 1'b0;
  endtask : ack_send

  // host fault only goes away through the resets
  task automatic ack_fault();
    @(negedge core_clk);
    host_fault_reset = 1'b1;
    @(negedge core_clk);
    host_fault_reset = 1'b0;
  endtask : ack_fault

  task automatic read_ctr(input logic [ISS_SEL_W-1:0] sel, output logic [ISS_DATA_W-1:0] dat);
    @(negedge core_clk);
    stat_rd = 1'b1;
    stat_sel = sel;
    @(negedge core_clk);
    stat_rd = 1'b0;
    stat_sel = ~sel;
    dat = stat_rd_data;
  endtask : read_ctr

  task automatic write_ctr(input logic [ISS_SEL_W-1:0] sel, input logic [ISS_DATA_W-1:0] dat);
    @(negedge core_clk);
    stat_wr = 1'b1;
    stat_sel = sel;
    stat_wr_data = dat;
    @(negedge core_clk);
    stat_wr = 1'b0;
    stat_sel = ~sel;
    stat_wr_data = ~dat;
  endtask : write_ctr
endmodule : iss_host_model

// *** tb/test_iss_intr_stats.sv ***
// self-checking bench for the interrupt and statistics unit
`timescale 1ns/100ps
module test_iss_intr_stats;
  import iss_pkg::*;
  typedef struct {int ev; logic msk; logic [15:0] cause; logic intr_n;} iss_row_t;
  logic core_clk, rst_n, arrival_pending, counting_on_bit, host_intr_n;
  logic [7:0] ev;
  logic cause_wr, mask_wr, send_result_wr, host_fault_reset, stat_rd, stat_wr;
  logic [ISS_CAUSE_W-1:0] cause_wr_data, mask_wr_data, interrupt_cause_reg, interrupt_mask_reg;
  logic [ISS_SEL_W-1:0] stat_sel;
  logic [ISS_DATA_W-1:0] stat_wr_data, stat_rd_data, d;
  logic tx_frame_end, tx_ok, tx_bcast, tx_mcast, tx_deferred, tx_long_defer, tx_carrier_lost;
  logic tx_coll_abort, tx_late_hit, rx_frame_end, rx_ok, rx_bcast, rx_mcast, rx_overrun_drop;
  logic [ISS_AMT_W-1:0] tx_bytes, rx_bytes;
  logic [4:0] tx_coll_cnt;
  logic [31:0] exp_c [16];
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  // event index, mask on, cause after the event, interrupt line
  iss_row_t rows [8] = '{'{0, 1, 16'h0003, 0}, '{1, 1, 16'h0005, 0}, '{2, 1, 16'h0021, 0},
    '{3, 0, 16'h0040, 1}, '{4, 1, 16'h0081, 0}, '{5, 0, 16'h0100, 1}, '{6, 1, 16'h0201, 0},
    '{7, 1, 16'h0401, 0}};

  iss_intr_stats u_dut (.core_clk, .rst_n, .host_fault_evt(ev[0]), .host_fault_reset,
    .send_done_evt(ev[1]), .send_result_wr, .arrival_pending, .early_arrival_evt(ev[2]),
    .software_request_evt(ev[3]), .link_change_evt(ev[4]), .send_transfer_done_evt(ev[5]),
    .arrival_transfer_done_evt(ev[6]), .control_frame_seen_evt(ev[7]), .cause_wr,
    .cause_wr_data, .mask_wr, .mask_wr_data, .interrupt_cause_reg, .interrupt_mask_reg,
    .host_intr_n, .counting_on_bit, .stat_rd, .stat_wr, .stat_sel, .stat_wr_data,
    .stat_rd_data, .tx_frame_end, .tx_ok, .tx_bcast, .tx_mcast, .tx_bytes, .tx_deferred,
    .tx_long_defer, .tx_coll_cnt, .tx_carrier_lost, .tx_coll_abort, .tx_late_hit,
    .rx_frame_end, .rx_ok, .rx_bcast, .rx_mcast, .rx_bytes, .rx_overrun_drop);

  iss_host_model u_host (.core_clk, .stat_rd_data, .cause_wr, .cause_wr_data, .mask_wr,
    .mask_wr_data, .send_result_wr, .host_fault_reset, .stat_rd, .stat_wr, .stat_sel,
    .stat_wr_data);

  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic pulse(input int i);
    @(negedge core_clk);
    ev[i] = 1'b1;
    @(negedge core_clk);
    ev[i] = 1'b0;
  endtask : pulse

  // expected counts follow the frame outcome, only while counting is on
  task automatic tx_frame(input logic ok, bc, mc, input logic [15:0] nb, input logic df, ld,
                          input logic [4:0] cc, input logic cl, ab);
    @(negedge core_clk);
    {tx_ok, tx_bcast, tx_mcast, tx_bytes, tx_deferred, tx_long_defer} = {ok, bc, mc, nb, df, ld};
    {tx_coll_cnt, tx_carrier_lost, tx_coll_abort, tx_frame_end} = {cc, cl, ab, 1'b1};
    if (counting_on_bit && ok) begin
      exp_c[0] += 1;
      exp_c[1] += 32'(bc);
      exp_c[2] += 32'(mc);
      exp_c[3] += 32'(nb);
      exp_c[6] += 32'(cc == 5'h01);
      exp_c[7] += 32'(cc >= 5'h02 && cc <= 5'h0F);
      exp_c[10] += 32'(cl);
    end
    if (counting_on_bit) begin
      exp_c[4] += 32'(df);
      exp_c[5] += 32'(ld);
      exp_c[9] += 32'(ab);
    end
    @(negedge core_clk);
    tx_frame_end = 1'b0;
  endtask : tx_frame

  task automatic rx_frame(input logic ok, bc, mc, input logic [15:0] nb, input logic ov);
    @(negedge core_clk);
    {rx_ok, rx_bcast, rx_mcast, rx_bytes, rx_overrun_drop} = {ok, bc, mc, nb, ov};
    rx_frame_end = 1'b1;
    if (counting_on_bit) begin
      exp_c[11] += 32'(ok);
      exp_c[12] += 32'(ok & bc);
      exp_c[13] += 32'(ok & mc);
      exp_c[14] += ok ? 32'(nb) : 32'h0;
      exp_c[15] += 32'(ov);
    end
    @(negedge core_clk);
    rx_frame_end = 1'b0;
  endtask : rx_frame

  task automatic late_hit();
    @(negedge core_clk);
    tx_late_hit = 1'b1;
    exp_c[8] += 32'(counting_on_bit);
    @(negedge core_clk);
    tx_late_hit = 1'b0;
  endtask : late_hit

  // every read returns the count and leaves the counter at zero
  task automatic check_all();
    for (int i = 0; i < ISS_NUM_CTR; i++) begin
      u_host.read_ctr(4'(i), d);
      check(d, exp_c[i]);
      exp_c[i] = 32'h0;
    end
  endtask : check_all

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, arrival_pending, counting_on_bit, ev, tx_frame_end, tx_ok, tx_bcast, tx_mcast} = '0;
    {tx_deferred, tx_long_defer, tx_carrier_lost, tx_coll_abort, tx_late_hit, tx_coll_cnt} = '0;
    {rx_frame_end, rx_ok, rx_bcast, rx_mcast, rx_overrun_drop, tx_bytes, rx_bytes} = '0;
    foreach (exp_c[i]) exp_c[i] = 32'h0;
    cyc(20);
    rst_n = 1'b1;
    check(32'(interrupt_cause_reg), 32'(ISS_CAUSE_RST));
    check(32'(host_intr_n), 32'h1);
    foreach (rows[r]) begin
      u_host.set_mask(rows[r].msk ? 16'hFFFF : 16'h0000);
      check(32'(interrupt_mask_reg), rows[r].msk ? 32'h07FE : 32'h0);
      pulse(rows[r].ev);
      cyc(1);
      check(32'(interrupt_cause_reg), 32'(rows[r].cause));
      check(32'(host_intr_n), 32'(rows[r].intr_n));
      u_host.write_cause(16'h001E);
      cyc(1);
      check(32'(interrupt_cause_reg), 32'(rows[r].cause));
      case (rows[r].ev)
        0: u_host.ack_fault();
        1: u_host.ack_send();
        default: u_host.write_cause(rows[r].cause & 16'hFFFE);
      endcase
      cyc(1);
      check(32'(interrupt_cause_reg), 32'(rows[r].cause & 16'h0001));
      check(32'(host_intr_n), 32'h1);
      u_host.ack_summary();
      check(32'(interrupt_cause_reg), 32'h0);
    end
    // early flag gives way to arrival done, also when both come together
    u_host.set_mask(16'h0028);
    pulse(2);
    cyc(1);
    check(32'(interrupt_cause_reg), 32'h0021);
    arrival_pending = 1'b1;
    cyc(2);
    check(32'(interrupt_cause_reg), 32'h0009);
    arrival_pending = 1'b0;
    cyc(2);
    check(32'(interrupt_cause_reg), 32'h0001);
    ev[2] = 1'b1;
    arrival_pending = 1'b1;
    cyc(1);
    ev[2] = 1'b0;
    cyc(1);
    check(32'(interrupt_cause_reg), 32'h0009);
    arrival_pending = 1'b0;
    cyc(2);
    u_host.ack_summary();
    check(32'(interrupt_cause_reg), 32'h0);
    // statistics: idle, disabled, then enabled traffic
    check_all();
    tx_frame(1, 1, 0, 16'h0040, 1, 0, 5'h01, 1, 0);
    rx_frame(1, 1, 0, 16'h0046, 0);
    check_all();
    counting_on_bit = 1'b1;
    tx_frame(1, 1, 0, 16'h0040, 1, 0, 5'h01, 1, 0);
    tx_frame(1, 0, 1, 16'h0064, 0, 1, 5'h0F, 0, 0);
    tx_frame(1, 0, 0, 16'h05EE, 0, 0, 5'h02, 0, 0);
    tx_frame(0, 0, 0, 16'h0000, 0, 0, 5'h10, 0, 1);
    repeat (3) late_hit();
    rx_frame(1, 1, 0, 16'h0046, 0);
    rx_frame(1, 0, 1, 16'h0050, 0);
    rx_frame(0, 0, 0, 16'h0000, 1);
    check_all();
    check_all();
    // near-full threshold, add on write, clear by read
    u_host.set_mask(16'h0010);
    u_host.write_ctr(4'h0, 32'h0000BFFF);
    cyc(3);
    check(32'(interrupt_cause_reg[ISS_B_NEAR_FULL]), 32'h0);
    u_host.write_ctr(4'h0, 32'h00000001);
    cyc(3);
    check(32'(interrupt_cause_reg), 32'h0011);
    check(32'(host_intr_n), 32'h0);
    u_host.read_ctr(4'h0, d);
    check(d, 32'h0000C000);
    cyc(3);
    check(32'(interrupt_cause_reg[ISS_B_NEAR_FULL]), 32'h0);
    check(32'(host_intr_n), 32'h1);
    u_host.ack_summary();
    u_host.write_ctr(4'h3, 32'h12345678);
    u_host.write_ctr(4'h3, 32'h12345678);
    u_host.read_ctr(4'h3, d);
    check(d, 32'h2468ACF0);
    u_host.write_ctr(4'h5, 32'h0000C000);
    cyc(2);
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    check(32'(interrupt_cause_reg), 32'(ISS_CAUSE_RST));
    check(32'(interrupt_mask_reg), 32'(ISS_MASK_RST));
    check(32'(host_intr_n), 32'h1);
    check(stat_rd_data, 32'h0);
    u_host.read_ctr(4'h5, d);
    check(d, 32'h0);
    finish_test();
  end
endmodule : test_iss_intr_stats
